// ==== src/dcs_pkg.sv ====
/*
  Shared constants and types for the debug clock switch host controller.
  Assumes a 40 MHz mclk and a device whose test port follows the usual
  four-bit instruction, five-bit chain select and least-significant-bit-first
  shifting.
*/
package dcs_pkg;
	// Clock and test clock timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int TCK_PERIOD_NS = 200;
	localparam int TCK_HALF_CYC = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	// Scan lengths.
	localparam int IR_LEN = 4;
	localparam int SEL_LEN = 5;
	localparam int CH1_LEN = 67;
	localparam int CH2_LEN = 38;
	// Test port instruction codes; plain defaults, not taken from any part.
	localparam logic [3:0] IR_SCAN_N = 4'h2;
	localparam logic [3:0] IR_INTEST = 4'hc;
	localparam logic [3:0] IR_RESTART = 4'h4;
	// Chain numbers and the status register address on chain 2.
	localparam logic [4:0] CHAIN_DEBUG = 5'h01;
	localparam logic [4:0] CHAIN_ICE = 5'h02;
	localparam logic [4:0] STATUS_ADDR = 5'h01;
	// Field layout of chain 1 and chain 2.
	localparam int INS_LSB = 1;
	localparam int SYS_BIT = 33;
	localparam int DAT_LSB = 35;
	localparam int CH2_ADDR_LSB = 32;
	localparam int CH2_RW_BIT = 37;
	localparam int DONE_BIT = 3;
	localparam int HALF_STATE_BIT = 4;
	localparam logic [31:0] NOP_INSTR = 32'he1a00000;
	// Test mode select walks, sent lowest bit first.
	localparam logic [5:0] TMS_RESET_PAT = 6'h1f;
	localparam logic [2:0] TMS_RESET_LEN = 3'h6;
	localparam logic [5:0] TMS_IR_PAT = 6'h03;
	localparam logic [2:0] TMS_IR_LEN = 3'h4;
	localparam logic [5:0] TMS_DR_PAT = 6'h01;
	localparam logic [2:0] TMS_DR_LEN = 3'h3;
	// Own register map.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_INSTR = 8'h04;
	localparam logic [7:0] A_CMD = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_DATA = 8'h10;
	localparam logic [7:0] A_DBGST = 8'h14;
	localparam int CTRL_HOLD = 0;
	localparam int CTRL_DUP = 1;
	localparam int CTRL_AUTORST = 2;
	localparam int ST_ERR = 5;
	// Command codes written to the command register.
	localparam logic [2:0] CMD_INJECT = 3'h1;
	localparam logic [2:0] CMD_SYSTEM_SPEED_FLAG = 3'h2;
	localparam logic [2:0] CMD_RESUME = 3'h3;
	localparam logic [2:0] CMD_POLL = 3'h4;
	localparam logic [2:0] CMD_TAPRESET = 3'h5;
	localparam logic [4:0] RST_PULSE_CYC = 5'h10;
	// Register port request and test port pins.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dcs_bus_t;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} dcs_jtag_t;
endpackage

// ==== src/dcs_tck_step.sv ====
/*
  One test clock period per request: sets TMS and TDI with TCK low, raises
  TCK, samples TDO near the end of the high phase and lowers TCK.
  Assumes TDO changes only on the falling edge of TCK.
*/
`timescale 1ns/1ps
module dcs_tck_step (
	input wire logic mclk, // System clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic step_req, // Start one test clock period.
	input wire logic step_tms, // Mode select for this period.
	input wire logic step_tdi, // Data in for this period.
	input wire logic tdo_pin, // Data out pin of the device.
	output dcs_pkg::dcs_jtag_t jtag, // Driven test port pins.
	output logic step_done, // Pulse when the period ends.
	output logic tdo_bit // Sampled data out.
);
	import dcs_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} dcs_step_t;
	localparam logic [3:0] HALF_LAST = 4'(TCK_HALF_CYC - 1);
	dcs_step_t st_reg;
	logic [3:0] cnt_reg;
	logic tck_reg, tms_reg, tdi_reg, done_reg, tdo_reg;
	logic tdo_s1_reg, tdo_s2_reg;
	logic last;

	// End of a half period.
	assign last = (cnt_reg == HALF_LAST);

	// Phase sequencing of one period.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			unique case (st_reg)
				ST_IDLE: begin
					cnt_reg <= 4'h0;
					if (step_req) st_reg <= ST_LOW;
				end
				ST_LOW, ST_HIGH: begin
					cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
					if (last) st_reg <= (st_reg == ST_LOW) ? ST_HIGH : ST_IDLE;
				end
			endcase
		end
	end

	// Pin drive and data out sampling.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tck_reg <= 1'b0;
			tms_reg <= 1'b1;
			tdi_reg <= 1'b0;
			done_reg <= 1'b0;
			tdo_reg <= 1'b0;
		end else begin
			done_reg <= (st_reg == ST_HIGH) && last;
			if (st_reg == ST_IDLE && step_req) begin
				tms_reg <= step_tms;
				tdi_reg <= step_tdi;
			end
			if (st_reg == ST_LOW && last) tck_reg <= 1'b1;
			if (st_reg == ST_HIGH && last) begin
				tck_reg <= 1'b0;
				tdo_reg <= tdo_s2_reg;
			end
		end
	end

	// Two-stage synchroniser for the data out pin.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tdo_s1_reg <= 1'b0;
			tdo_s2_reg <= 1'b0;
		end else begin
			tdo_s1_reg <= tdo_pin;
			tdo_s2_reg <= tdo_s1_reg;
		end
	end

	// Outputs.
	assign jtag = '{tck: tck_reg, tms: tms_reg, tdi: tdi_reg};
	assign step_done = done_reg;
	assign tdo_bit = tdo_reg;

	tck_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(tck_reg) |-> tck_reg[*4] ##1 !tck_reg) else $error("TCK high phase wrong");
	done_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
		step_done |-> ##1 !step_done ##0 !tck_reg) else $error("Step done not a pulse");
endmodule // dcs_tck_step

// ==== src/dcs_debug_host.sv ====
/*
  Debug host controller: walks the device test port to inject instructions,
  run system-speed accesses, resume and read the debug status register.
  Assumes a device that switches its own core clock and a software master
  on the plain register port.
*/
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module dcs_debug_host (
	input wire logic mclk, // System clock, 40 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input dcs_pkg::dcs_bus_t bus, // Register port request.
	output logic [31:0] rdata, // Read data, one cycle after read.
	output dcs_pkg::dcs_jtag_t jtag, // Test port pins to the device.
	input wire logic tdo, // Test data out from the device.
	input wire logic debug_acknowledge, // Device is in debug state.
	output logic memory_clock_hold, // Holds the memory clock low.
	output logic system_reset_req // System reset request.
);
	import dcs_pkg::*;
	typedef enum logic [3:0] {C_IDLE, C_RESET, C_IR_SCANN, C_DR_CHAIN, C_IR_INTEST,
		C_INSTR, C_NOP, C_RESTART, C_POLL_ADDR, C_POLL_READ} dcs_cmd_t;
	typedef enum logic [1:0] {E_IDLE, E_PRE, E_SHIFT, E_POST} dcs_eng_t;
	dcs_cmd_t cmd_st_reg;
	dcs_eng_t eng_st_reg;
	logic [2:0] op_reg;
	logic [4:0] chain_reg;
	logic [31:0] instr_reg, data_reg, dbgst_reg, rdata_reg;
	logic hold_reg, dup_reg, autorst_reg, err_reg, flag_reg, ir_restart_reg;
	logic launched_reg, wait_reg, eng_done_reg;
	logic [6:0] idx_reg, len_reg;
	logic [5:0] pat_reg;
	logic [2:0] plen_reg;
	logic [CH1_LEN-1:0] sh_reg, cap_reg;
	logic [4:0] rst_cnt_reg;
	logic ack_s1_reg, ack_s2_reg;
	logic [5:0] p_pat;
	logic [2:0] p_len;
	logic [6:0] p_slen;
	logic [CH1_LEN-1:0] p_data;
	logic [31:0] ins_eff;
	logic step_req, step_tms, step_tdi, step_done, tdo_bit;
	logic start, cmd_wr, accept, busy;

	// Debug step class: data processing, single or multiple loads and stores.
	function automatic logic dbg_legal(input logic [31:0] ins);
		dbg_legal = (ins[27:26] != 2'b11) && (ins[27:25] != 3'b101);
	endfunction
	// System-speed class: single or multiple loads and stores only.
	function automatic logic sys_legal(input logic [31:0] ins);
		sys_legal = (ins[27:26] == 2'b01) || (ins[27:25] == 3'b100);
	endfunction

	// Synchroniser for the debug acknowledge pin.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end else begin
			ack_s1_reg <= debug_acknowledge;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	// Command acceptance; stepping needs the device in debug state.
	assign busy = (cmd_st_reg != C_IDLE);
	assign cmd_wr = bus.wr && (bus.addr == A_CMD) && !busy;
	always_comb begin
		unique case (bus.wdata[2:0])
			CMD_INJECT: accept = ack_s2_reg && (dup_reg || dbg_legal(instr_reg));
			CMD_SYSTEM_SPEED_FLAG: accept = ack_s2_reg && (dup_reg || sys_legal(instr_reg));
			CMD_RESUME, CMD_POLL, CMD_TAPRESET: accept = 1'b1;
			default: accept = 1'b0;
		endcase
	end

	// Half-width instructions are copied into both halves.
	assign ins_eff = dup_reg ? {instr_reg[15:0], instr_reg[15:0]} : instr_reg;

	// Scan parameters for the current command step.
	always_comb begin
		p_pat = TMS_DR_PAT;
		p_len = TMS_DR_LEN;
		p_slen = 7'h00;
		p_data = '0;
		unique case (cmd_st_reg)
			C_IDLE: ;
			C_RESET: begin
				p_pat = TMS_RESET_PAT;
				p_len = TMS_RESET_LEN;
			end
			C_IR_SCANN, C_IR_INTEST, C_RESTART: begin
				p_pat = TMS_IR_PAT;
				p_len = TMS_IR_LEN;
				p_slen = 7'(IR_LEN);
				p_data[3:0] = (cmd_st_reg == C_IR_SCANN) ? IR_SCAN_N :
					(cmd_st_reg == C_IR_INTEST) ? IR_INTEST : IR_RESTART;
			end
			C_DR_CHAIN: begin
				p_slen = 7'(SEL_LEN);
				p_data[4:0] = chain_reg;
			end
			C_INSTR: begin
				p_slen = 7'(CH1_LEN);
				p_data[INS_LSB+:32] = ins_eff;
				p_data[SYS_BIT] = 1'b0;
			end
			C_NOP: begin
				p_slen = 7'(CH1_LEN);
				p_data[INS_LSB+:32] = NOP_INSTR;
				p_data[SYS_BIT] = 1'b1;
			end
			C_POLL_ADDR, C_POLL_READ: begin
				p_slen = 7'(CH2_LEN);
				p_data[CH2_ADDR_LSB+:5] = STATUS_ADDR;
				p_data[CH2_RW_BIT] = 1'b0;
			end
		endcase
	end

	// Command sequencing through the test port.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_st_reg <= C_RESET;
			op_reg <= CMD_TAPRESET;
			chain_reg <= CHAIN_DEBUG;
		end else if (cmd_wr && accept) begin
			op_reg <= bus.wdata[2:0];
			chain_reg <= (bus.wdata[2:0] == CMD_POLL) ? CHAIN_ICE : CHAIN_DEBUG;
			unique case (bus.wdata[2:0])
				CMD_RESUME: cmd_st_reg <= C_RESTART;
				CMD_TAPRESET: cmd_st_reg <= C_RESET;
				default: cmd_st_reg <= C_IR_SCANN;
			endcase
		end else if (eng_done_reg) begin
			unique case (cmd_st_reg)
				C_IDLE, C_RESET: cmd_st_reg <= C_IDLE;
				C_IR_SCANN: cmd_st_reg <= C_DR_CHAIN;
				C_DR_CHAIN: cmd_st_reg <= C_IR_INTEST;
				C_IR_INTEST: cmd_st_reg <= (chain_reg == CHAIN_DEBUG) ? C_INSTR : C_POLL_ADDR;
				C_INSTR: cmd_st_reg <= (op_reg == CMD_SYSTEM_SPEED_FLAG) ? C_NOP : C_IDLE;
				C_NOP: cmd_st_reg <= C_RESTART;
				C_RESTART: begin
					// After the flagged access the device re-enters debug by itself.
					cmd_st_reg <= (op_reg == CMD_SYSTEM_SPEED_FLAG) ? C_IR_SCANN : C_IDLE;
					chain_reg <= CHAIN_ICE;
				end
				C_POLL_ADDR: cmd_st_reg <= C_POLL_READ;
				C_POLL_READ: begin
					// The access may stall for ever, so keep polling the done bit.
					if (op_reg == CMD_SYSTEM_SPEED_FLAG && !cap_reg[DONE_BIT]) begin
						cmd_st_reg <= C_POLL_ADDR;
					end else begin
						cmd_st_reg <= C_IDLE;
					end
				end
			endcase
		end
	end

	// Scan engine: mode walk, shift with exit on the last bit, update to idle.
	assign start = busy && (eng_st_reg == E_IDLE) && !launched_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			eng_st_reg <= E_IDLE;
			launched_reg <= 1'b0;
			wait_reg <= 1'b0;
			eng_done_reg <= 1'b0;
			idx_reg <= 7'h00;
			len_reg <= 7'h00;
			pat_reg <= 6'h00;
			plen_reg <= 3'h0;
			sh_reg <= '0;
		end else begin
			eng_done_reg <= 1'b0;
			if (eng_done_reg) launched_reg <= 1'b0;
			if (start) begin
				launched_reg <= 1'b1;
				eng_st_reg <= E_PRE;
				idx_reg <= 7'h00;
				pat_reg <= p_pat;
				plen_reg <= p_len;
				len_reg <= p_slen;
				sh_reg <= p_data;
			end else if (step_req) begin
				wait_reg <= 1'b1;
			end else if (step_done) begin
				wait_reg <= 1'b0;
				idx_reg <= idx_reg + 7'h01;
				unique case (eng_st_reg)
					E_IDLE: ;
					E_PRE: begin
						if (idx_reg[2:0] == plen_reg - 3'h1) begin
							idx_reg <= 7'h00;
							eng_st_reg <= (len_reg == 7'h00) ? E_IDLE : E_SHIFT;
							eng_done_reg <= (len_reg == 7'h00);
						end
					end
					E_SHIFT: begin
						if (idx_reg == len_reg - 7'h01) begin
							idx_reg <= 7'h00;
							eng_st_reg <= E_POST;
						end
					end
					E_POST: begin
						if (idx_reg == 7'h01) begin
							eng_st_reg <= E_IDLE;
							eng_done_reg <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Captured data out bits, one per shifted bit.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cap_reg <= '0;
		end else if (step_done && eng_st_reg == E_SHIFT) begin
			cap_reg[idx_reg] <= tdo_bit;
		end
	end

	// Step request and pin values for the current position.
	assign step_req = (eng_st_reg != E_IDLE) && !wait_reg && !start;
	always_comb begin
		step_tdi = 1'b0;
		unique case (eng_st_reg)
			E_IDLE: step_tms = 1'b0;
			E_PRE: step_tms = pat_reg[idx_reg[2:0]];
			E_SHIFT: begin
				step_tms = (idx_reg == len_reg - 7'h01);
				step_tdi = sh_reg[idx_reg];
			end
			E_POST: step_tms = (idx_reg == 7'h00);
		endcase
	end

	dcs_tck_step u_step (
		.mclk(mclk),
		.reset_n(reset_n),
		.step_req(step_req),
		.step_tms(step_tms),
		.step_tdi(step_tdi),
		.tdo_pin(tdo),
		.jtag(jtag),
		.step_done(step_done),
		.tdo_bit(tdo_bit)
	);

	// Results of completed scans.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			data_reg <= 32'h0;
			dbgst_reg <= 32'h0;
			flag_reg <= 1'b0;
			ir_restart_reg <= 1'b0;
		end else if (eng_done_reg) begin
			if (cmd_st_reg == C_INSTR || cmd_st_reg == C_NOP) begin
				data_reg <= cap_reg[DAT_LSB+:32];
				flag_reg <= cap_reg[SYS_BIT];
			end
			if (cmd_st_reg == C_POLL_READ) dbgst_reg <= cap_reg[31:0];
			if (cmd_st_reg == C_RESTART) ir_restart_reg <= 1'b1;
			else if (cmd_st_reg inside {C_RESET, C_IR_SCANN, C_IR_INTEST}) ir_restart_reg <= 1'b0;
		end
	end

	// Control bits; the memory clock is released only once resume is selected.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hold_reg <= 1'b0;
			dup_reg <= 1'b0;
			autorst_reg <= 1'b0;
			instr_reg <= 32'h0;
		end else if (bus.wr) begin
			if (bus.addr == A_CTRL) begin
				hold_reg <= bus.wdata[CTRL_HOLD] || (hold_reg && !ir_restart_reg);
				dup_reg <= bus.wdata[CTRL_DUP];
				autorst_reg <= bus.wdata[CTRL_AUTORST];
			end
			if (bus.addr == A_INSTR) instr_reg <= bus.wdata;
		end
	end

	// Refused command flag; a new refusal wins over a clear.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			err_reg <= 1'b0;
		end else if (bus.wr && bus.addr == A_CMD && (busy || !accept)) begin
			err_reg <= 1'b1;
		end else if (bus.wr && bus.addr == A_STATUS && bus.wdata[ST_ERR]) begin
			err_reg <= 1'b0;
		end
	end

	// System reset pulse after a resume when enabled.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_cnt_reg <= 5'h00;
		end else if (eng_done_reg && cmd_st_reg == C_RESTART && op_reg == CMD_RESUME
			&& autorst_reg) begin
			rst_cnt_reg <= RST_PULSE_CYC;
		end else if (rst_cnt_reg != 5'h00) begin
			rst_cnt_reg <= rst_cnt_reg - 5'h01;
		end
	end

	// Register read data, valid the cycle after the read strobe.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				A_CTRL: rdata_reg <= {29'h0, autorst_reg, dup_reg, hold_reg};
				A_INSTR: rdata_reg <= instr_reg;
				A_STATUS: rdata_reg <= {25'h0, hold_reg, err_reg, flag_reg,
					dbgst_reg[HALF_STATE_BIT], dbgst_reg[DONE_BIT], ack_s2_reg, busy};
				A_DATA: rdata_reg <= data_reg;
				A_DBGST: rdata_reg <= dbgst_reg;
				default: rdata_reg <= 32'h0;
			endcase
		end else begin
			rdata_reg <= 32'h0;
		end
	end

	// Outputs.
	assign rdata = rdata_reg;
	assign memory_clock_hold = hold_reg;
	assign system_reset_req = (rst_cnt_reg != 5'h00);

	hold_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(hold_reg) |-> $past(ir_restart_reg)) else $error("Hold released early");
	ch1_length_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(eng_st_reg == E_SHIFT && step_req && step_tms && cmd_st_reg == C_INSTR)
		|-> idx_reg == 7'h42) else $error("Chain 1 scan not 67 bits");
	nop_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(eng_st_reg == E_SHIFT && step_req && idx_reg == 7'h21)
		|-> (cmd_st_reg == C_NOP) == step_tdi || cmd_st_reg != C_NOP && cmd_st_reg != C_INSTR)
		else $error("System speed flag wrong");
	sys_legal_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(cmd_wr && accept && bus.wdata[2:0] == CMD_SYSTEM_SPEED_FLAG) |-> ##1
		cmd_st_reg == C_IR_SCANN && (dup_reg || sys_legal(instr_reg)))
		else $error("Illegal system speed instruction");
	inject_legal_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(cmd_st_reg == C_INSTR && start) |-> (dup_reg || dbg_legal(instr_reg)) && ack_s2_reg)
		else $error("Illegal debug instruction");
	restart_order_a: assert property (@(posedge mclk) disable iff (!reset_n)
		($rose(cmd_st_reg == C_RESTART) && op_reg == CMD_SYSTEM_SPEED_FLAG)
		|-> $past(cmd_st_reg) == C_NOP) else $error("Resume before last instruction");
	poll_loop_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(eng_done_reg && cmd_st_reg == C_POLL_READ && op_reg == CMD_SYSTEM_SPEED_FLAG
		&& !cap_reg[DONE_BIT]) |=> cmd_st_reg == C_POLL_ADDR && start)
		else $error("Polling stopped early");
	dup_halves_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(start && cmd_st_reg == C_INSTR && dup_reg) |=> sh_reg[16:1] == sh_reg[32:17])
		else $error("Half-width copy missing");
endmodule // dcs_debug_host

// ==== verification/dcs_dev_model.sv ====
/*
  Behavioural model of the debug device: test port, chains 1 and 2, debug state.
  Assumes the host keeps the test clock slow against mclk.
*/
`timescale 1ns/1ps
module dcs_dev_model #(
	parameter logic HALF = 1'b1,
	parameter logic [31:0] MDATA = 32'h5a3c0f96,
	// Memory stall of a system-speed access, long enough that the first poll sees it busy.
	parameter int STALL_CYC = 1000
) (
	input wire logic mclk, // System clock.
	input dcs_pkg::dcs_jtag_t jtag, // Test port pins.
	output logic tdo, // Test data out.
	output logic debug_acknowledge, // Device in debug state.
	input wire logic enter_debug, // Rising edge enters debug.
	input wire logic enter_cause, // One for watchpoint, zero for breakpoint.
	output logic [31:0] last_instr, // Last instruction scanned in.
	output logic [31:0] prev_instr, // The one before it.
	output logic last_flag, // Speed flag of the last scan.
	output logic [7:0] debug_steps // Step clock pulses seen by the core.
);
	import dcs_pkg::*;
	int t1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
	int t0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
	int st = 0;
	int nx;
	int len;
	int cnt = 0;
	logic [66:0] sr = '0;
	logic [3:0] ir = 4'h0;
	logic [4:0] chain = 5'h0;
	logic [31:0] rdw = 32'h0;
	logic capflag = 1'b0;
	logic flag = 1'b0;
	logic done = 1'b0;
	logic run_sys = 1'b0;
	logic debug_step_clock = 1'b0;
	logic core_on_debug = 1'b0;
	logic selected_core_clock_out;
	// Outputs start from a known level.
	initial begin
		tdo = 1'b0;
		debug_acknowledge = 1'b0;
		last_instr = 32'h0;
		prev_instr = 32'h0;
		last_flag = 1'b0;
		debug_steps = 8'h00;
	end
	// The core follows the acknowledge at the next falling edge, so no runt pulse appears.
	always @(negedge mclk) core_on_debug = debug_acknowledge;
	// Memory clock outside debug, step clock inside; the step clock idles low.
	assign selected_core_clock_out = core_on_debug ? debug_step_clock : mclk;
	// Counts the core clocks that arrive while the core runs from the step clock.
	always @(posedge selected_core_clock_out) begin
		if (core_on_debug) debug_steps = debug_steps + 8'h01;
	end
	// Test port state walk with capture, shift and update of each register.
	always @(posedge jtag.tck) begin
		nx = jtag.tms ? t1[st] : t0[st];
		len = (st > 8) ? IR_LEN : (ir == IR_SCAN_N) ? SEL_LEN :
			(chain == CHAIN_DEBUG) ? CH1_LEN : CH2_LEN;
		case (st)
			3: begin
				sr = '0;
				if (ir == IR_SCAN_N) sr[4:0] = 5'h10;
				else if (chain == CHAIN_DEBUG) sr[DAT_LSB+:32] = MDATA;
				else sr[31:0] = rdw;
				if (ir != IR_SCAN_N && chain == CHAIN_DEBUG) sr[SYS_BIT] = capflag;
			end
			10: sr = 67'h1;
			4, 11: begin
				sr = sr >> 1;
				sr[len-1] = jtag.tdi;
			end
			15: ir = sr[3:0];
			8: begin
				if (ir == IR_SCAN_N) chain = sr[4:0];
				else if (chain == CHAIN_DEBUG) begin
					prev_instr = last_instr;
					last_instr = sr[INS_LSB+:32];
					last_flag = sr[SYS_BIT];
					flag = sr[SYS_BIT];
				end else if (!sr[CH2_RW_BIT] && sr[CH2_ADDR_LSB+:5] == STATUS_ADDR)
					rdw = {27'h0, HALF, done, 3'h0};
			end
			default: ;
		endcase
		// Resume selected and idle entered: leave debug, flagged access runs.
		if (nx == 1 && st != 1 && ir == IR_RESTART && debug_acknowledge) begin
			debug_acknowledge = 1'b0;
			run_sys = flag;
		end
		// Internal test on chain 1 in debug, or on chain 0: one step clock on entering idle.
		if (nx == 1 && st == 8 && ir == IR_INTEST
			&& (debug_acknowledge && chain == CHAIN_DEBUG || chain == 5'h00)) begin
			debug_step_clock = 1'b1;
		end
		st = nx;
	end
	// Data out changes on the falling edge and is not held outside shifts.
	// The step clock pulse ends with the test clock high phase.
	always @(negedge jtag.tck) begin
		tdo = (st == 4 || st == 11) ? sr[0] : ~tdo;
		debug_step_clock = 1'b0;
	end
	// The stalled access only counts on the memory clock; then debug is re-entered.
	always @(posedge mclk) begin
		if (run_sys && !core_on_debug) cnt = cnt + 1;
		if (cnt == STALL_CYC) begin
			cnt = 0;
			run_sys = 1'b0;
			flag = 1'b0;
			done = 1'b1;
			capflag = 1'b1;
			debug_acknowledge = 1'b1;
		end
	end
	// Debug entry raises the acknowledge and records the cause.
	always @(posedge enter_debug) begin
		debug_acknowledge = 1'b1;
		done = 1'b0;
		capflag = enter_cause;
	end
endmodule // dcs_dev_model

// ==== verification/dcs_debug_host_tb_top.sv ====
/*
  Self-checking bench for the debug host controller against a device model.
  Assumes the register port answers one cycle after a read strobe.
*/
`timescale 1ns/1ps
module dcs_debug_host_tb_top;
	import dcs_pkg::*;
	localparam logic [31:0] MDAT = 32'h5a3c0f96;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	dcs_bus_t bus = '0;
	dcs_jtag_t jtag;
	logic [31:0] rdata, got, last_instr, prev_instr;
	logic tdo, ack, hold, rst_req, last_flag;
	logic enter = 1'b0;
	logic cause = 1'b0;
	logic [7:0] steps;
	int fail_count = 0;
	int checks_done = 0;
	int rst_len = 0;
	// Clock of 25 ns.
	always #12.5 mclk = ~mclk;
	dcs_debug_host dut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.jtag(jtag), .tdo(tdo), .debug_acknowledge(ack), .memory_clock_hold(hold),
		.system_reset_req(rst_req));
	dcs_dev_model #(.HALF(1'b1), .MDATA(MDAT)) model (.mclk(mclk), .jtag(jtag), .tdo(tdo),
		.debug_acknowledge(ack), .enter_debug(enter), .enter_cause(cause),
		.last_instr(last_instr), .prev_instr(prev_instr), .last_flag(last_flag),
		.debug_steps(steps));
	// Counts the cycles of the system reset request.
	always @(posedge mclk) if (rst_req === 1'b1) rst_len <= rst_len + 1;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic cmd(input logic [2:0] c);
		int n;
		n = 0;
		wr(A_CMD, {29'h0, c});
		do begin
			rd(A_STATUS);
			n++;
		end while (got[0] !== 1'b0 && n < 8000);
		chk({31'h0, got[0]}, 32'h0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well beyond the expected run.
	initial begin
		#2000000;
		fail_count++;
		tally_and_finish();
	end
	// Main sequence of tests.
	initial begin
		repeat (10) @(posedge mclk);
		chk({27'h0, jtag, hold, rst_req}, 32'h8);
		chk(rdata, 32'h0);
		reset_n <= 1'b1;
		wr(A_CMD, {29'h0, CMD_INJECT});
		rd(A_STATUS);
		chk(got & 32'h21, 32'h21);
		cmd(CMD_TAPRESET);
		chk(got & 32'h21, 32'h20);
		wr(A_STATUS, 32'h20);
		cmd(CMD_TAPRESET);
		chk(got & 32'h21, 32'h0);
		rd(8'h20);
		chk(got, 32'h0);
		wr(A_CMD, {29'h0, CMD_INJECT});
		rd(A_STATUS);
		chk(got & 32'h20, 32'h20);
		wr(A_STATUS, 32'h20);
		$display("test reset and refusal done");
		enter <= 1'b1;
		repeat (4) @(posedge mclk);
		wr(A_CTRL, 32'h2);
		wr(A_INSTR, 32'h00004700);
		cmd(CMD_INJECT);
		chk(last_instr, 32'h47004700);
		chk({31'h0, last_flag}, 32'h0);
		rd(A_STATUS);
		chk(got & 32'h32, 32'h02);
		rd(A_DATA);
		chk(got, MDAT);
		wr(A_CTRL, 32'h0);
		wr(A_INSTR, 32'hea000000);
		wr(A_CMD, {29'h0, CMD_INJECT});
		rd(A_STATUS);
		chk(got & 32'h20, 32'h20);
		wr(A_STATUS, 32'h20);
		wr(A_INSTR, NOP_INSTR);
		wr(A_CMD, {29'h0, CMD_SYSTEM_SPEED_FLAG});
		rd(A_STATUS);
		chk(got & 32'h20, 32'h20);
		wr(A_STATUS, 32'h20);
		wr(A_INSTR, 32'he129f000);
		cmd(CMD_INJECT);
		chk(last_instr, 32'he129f000);
		$display("test debug inject done");
		wr(A_INSTR, 32'he5901000);
		cmd(CMD_SYSTEM_SPEED_FLAG);
		chk(prev_instr, 32'he5901000);
		chk(last_instr, NOP_INSTR);
		chk({31'h0, last_flag}, 32'h1);
		rd(A_STATUS);
		chk(got & 32'h26, 32'h06);
		rd(A_DBGST);
		chk(got & 32'h18, 32'h18);
		cmd(CMD_INJECT);
		rd(A_STATUS);
		chk(got & 32'h10, 32'h10);
		chk({24'h0, steps}, 32'h5);
		cmd(CMD_POLL);
		rd(A_DBGST);
		chk(got & 32'h18, 32'h18);
		$display("test system speed done");
		wr(A_CTRL, 32'h5);
		#1 chk({31'h0, hold}, 32'h1);
		wr(A_CTRL, 32'h4);
		#1 chk({31'h0, hold}, 32'h1);
		cmd(CMD_RESUME);
		repeat (40) @(posedge mclk);
		rd(A_STATUS);
		chk(got & 32'h22, 32'h0);
		chk(rst_len, 32'h10);
		wr(A_CTRL, 32'h0);
		#1 chk({31'h0, hold}, 32'h0);
		enter <= 1'b0;
		cause <= 1'b1;
		repeat (2) @(posedge mclk);
		enter <= 1'b1;
		repeat (4) @(posedge mclk);
		cmd(CMD_INJECT);
		rd(A_STATUS);
		chk(got & 32'h13, 32'h12);
		$display("test resume done");
		tally_and_finish();
	end
endmodule // dcs_debug_host_tb_top
